//--- rtl/apc_pkg.sv
// package of the converter power and output configuration registers
// assumes an external serial port decoder that issues byte-wide
// register reads and writes on the sample clock
package apc_pkg;

	// ==========================================================
	// register port widths
	localparam int          APC_ADDR_W = 9;
	localparam int          APC_DATA_W = 8;
	localparam int          APC_LANES  = 4;

	// ==========================================================
	// register offsets
	localparam logic [8:0]  APC_OFS_POWER  = 9'h008;
	localparam logic [8:0]  APC_OFS_ENH    = 9'h00C;
	localparam logic [8:0]  APC_OFS_OMODE  = 9'h014;
	localparam logic [8:0]  APC_OFS_OADJ   = 9'h015;
	localparam logic [8:0]  APC_OFS_PHASE  = 9'h016;
	localparam logic [8:0]  APC_OFS_XFER   = 9'h0FF;
	localparam logic [8:0]  APC_OFS_OVRD   = 9'h100;
	localparam logic [8:0]  APC_OFS_UIO2   = 9'h101;
	localparam logic [8:0]  APC_OFS_UIO3   = 9'h102;

	// ==========================================================
	// writable bit masks, open bits are zero
	localparam logic [7:0]  APC_MSK_POWER  = 8'h23;
	localparam logic [7:0]  APC_MSK_ENH    = 8'h04;
	localparam logic [7:0]  APC_MSK_OMODE  = 8'h45;
	localparam logic [7:0]  APC_MSK_OADJ   = 8'h31;
	localparam logic [7:0]  APC_MSK_PHASE  = 8'h7F;
	localparam logic [7:0]  APC_MSK_OVRD   = 8'h77;
	localparam logic [7:0]  APC_MSK_UIO2   = 8'h01;
	localparam logic [7:0]  APC_MSK_UIO3   = 8'h08;

	// ==========================================================
	// reset values
	localparam logic [7:0]  APC_RST_POWER  = 8'h00;
	localparam logic [7:0]  APC_RST_ENH    = 8'h00;
	localparam logic [7:0]  APC_RST_OMODE  = 8'h01;
	localparam logic [7:0]  APC_RST_OADJ   = 8'h00;
	localparam logic [7:0]  APC_RST_PHASE  = 8'h03;
	localparam logic [7:0]  APC_RST_OVRD   = 8'h00;
	localparam logic [7:0]  APC_RST_UIO    = 8'h00;

	// ==========================================================
	// field positions
	localparam int          APC_PIN_FUNC_BIT = 5;
	localparam int          APC_CHOP_BIT     = 2;
	localparam int          APC_LEVEL_BIT    = 6;
	localparam int          APC_INVERT_BIT   = 2;
	localparam int          APC_FORMAT_BIT   = 0;
	localparam int          APC_DRIVE_BIT    = 0;
	localparam int          APC_TERM_LSB     = 4;
	localparam int          APC_INPH_LSB     = 4;
	localparam int          APC_XFER_BIT     = 0;
	localparam int          APC_PULLDN_BIT   = 0;
	localparam int          APC_CMGEN_BIT    = 3;
	localparam logic [3:0]  APC_OUTPH_MAX    = 4'hB;
	localparam logic [7:0]  APC_OUTPH_STEP   = 8'h3C;

	// ==========================================================
	// internal power mode encodings
	localparam logic [1:0]  APC_PM_NORMAL    = 2'h0;
	localparam logic [1:0]  APC_PM_FULL_DOWN = 2'h1;
	localparam logic [1:0]  APC_PM_STANDBY   = 2'h2;
	localparam logic [1:0]  APC_PM_DIG_RESET = 2'h3;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic       level_ieee;
		logic       invert;
		logic       twos_complement;
		logic [1:0] termination;
		logic       double_drive;
	} apc_lane_cfg_t;

	typedef struct packed {
		logic       clock_enable;
		logic       datapath_reset;
		logic       outputs_enable;
	} apc_power_ctl_t;

	typedef struct packed {
		logic       enable;
		logic [1:0] resolution;
		logic [2:0] rate;
	} apc_override_t;

endpackage

//--- rtl/apc_lane_cfg.sv
// per-lane output mode and output adjust registers
// assumes write strobes already qualified by the channel index
`timescale 1ns/1ns
module apc_lane_cfg
	import apc_pkg::*;
(
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	// qualified writes
	input  wire logic                  i_write_mode,
	input  wire logic                  i_write_adjust,
	input  wire logic [7:0]            i_wdata,
	// stored values and decoded configuration
	output logic      [7:0]            o_mode_r,
	output logic      [7:0]            o_adjust_r,
	output apc_lane_cfg_t              o_cfg
);

	// ==========================================================
	// storage, open bits never stored
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			o_mode_r <= APC_RST_OMODE;
		else if (i_write_mode)
			o_mode_r <= i_wdata & APC_MSK_OMODE;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			o_adjust_r <= APC_RST_OADJ;
		else if (i_write_adjust)
			o_adjust_r <= i_wdata & APC_MSK_OADJ;
	end

	// ==========================================================
	// decode, registered so the pins see flip-flops
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			o_cfg <= '0;
		else
		begin
			o_cfg.level_ieee      <= o_mode_r[APC_LEVEL_BIT];
			o_cfg.invert          <= o_mode_r[APC_INVERT_BIT];
			o_cfg.twos_complement <= o_mode_r[APC_FORMAT_BIT];
			o_cfg.termination     <= o_adjust_r[APC_TERM_LSB +: 2];
			// termination wins over double drive
			o_cfg.double_drive    <= o_adjust_r[APC_DRIVE_BIT]
				& (o_adjust_r[APC_TERM_LSB +: 2] == 2'h0);
		end
	end

endmodule

//--- rtl/apc_config_regs.sv
// configuration registers for power modes, output format and clock phase
// assumes a serial port front end that presents byte accesses in the
// sample clock domain and keeps the channel index registers itself
`timescale 1ns/1ns

module apc_config_regs
	import apc_pkg::*;
(
	// clock and reset
	input  wire logic                  i_clock,
	input  wire logic                  i_reset,
	// register access from the serial port
	input  wire logic [8:0]            i_reg_addr,
	input  wire logic [7:0]            i_reg_wdata,
	input  wire logic                  i_reg_write,
	input  wire logic                  i_reg_read,
	output logic      [7:0]            o_reg_rdata,
	output logic                       o_reg_rvalid,
	// channel index held by the serial port
	input  wire logic [3:0]            i_data_channel_select,
	input  wire logic [3:0]            i_clock_channel_select,
	// external power-down pin
	input  wire logic                  i_power_down_pin,
	// datapath power control
	output apc_power_ctl_t             o_power_ctl,
	output logic                       o_channels_active,
	output logic                       o_chop_enable,
	// output lanes
	output apc_lane_cfg_t [3:0]        o_lane_cfg,
	// clock phase
	output logic      [2:0]            o_input_phase_cycles,
	output logic      [3:0]            o_data_clock_phase,
	output logic      [9:0]            o_data_clock_degrees,
	// capability override, serial pin, common mode
	output apc_override_t              o_override,
	output logic                       o_serial_pin_pulldown_en,
	output logic                       o_common_mode_gen_down
);

	// ==========================================================
	// helpers
	// lowest selected lane, used for both lane register reads
	function automatic logic [1:0] lowest_lane(input logic [3:0] sel);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 3; i >= 0; i--)
			if (sel[i])
				idx = 2'(i);
		return idx;
	endfunction

	function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
		return a == ofs;
	endfunction

	// phase code to degrees; widened first so 11 x 60 cannot wrap
	function automatic logic [9:0] phase_degrees(input logic [3:0] code);
		return 10'(code) * 10'(APC_OUTPH_STEP);
	endfunction

	// ==========================================================
	// global register storage
	logic [7:0]            power_r;
	logic [7:0]            enh_r;
	logic [7:0]            phase_r;
	logic [7:0]            ovrd_r;
	logic [7:0]            uio2_r;
	logic [7:0]            uio3_r;
	logic [7:0]            mode_q    [APC_LANES];
	logic [7:0]            adjust_q  [APC_LANES];
	logic [1:0]            eff_mode_nxt;
	logic                  xfer_strobe;
	logic [3:0]            phase_code_nxt;

	// power modes, cleared only by the power-on reset input
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			power_r <= APC_RST_POWER;
		else if (i_reg_write && hit(i_reg_addr, APC_OFS_POWER))
			power_r <= i_reg_wdata & APC_MSK_POWER;
	end

	// enhancement control
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			enh_r <= APC_RST_ENH;
		else if (i_reg_write && hit(i_reg_addr, APC_OFS_ENH))
			enh_r <= i_reg_wdata & APC_MSK_ENH;
	end

	// output phase; codes past 1011 keep the old output code
	always_comb
	begin
		phase_code_nxt = i_reg_wdata[3:0];
		if (i_reg_wdata[3:0] > APC_OUTPH_MAX)
			phase_code_nxt = phase_r[3:0];
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			phase_r <= APC_RST_PHASE;
		else if (i_reg_write && hit(i_reg_addr, APC_OFS_PHASE))
			phase_r <= {1'b0, i_reg_wdata[6:4], phase_code_nxt};
	end

	// override staging register, not yet effective
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			ovrd_r <= APC_RST_OVRD;
		else if (i_reg_write && hit(i_reg_addr, APC_OFS_OVRD))
			ovrd_r <= i_reg_wdata & APC_MSK_OVRD;
	end

	// user I/O registers
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			uio2_r <= APC_RST_UIO;
			uio3_r <= APC_RST_UIO;
		end
		else if (i_reg_write)
		begin
			if (hit(i_reg_addr, APC_OFS_UIO2))
				uio2_r <= i_reg_wdata & APC_MSK_UIO2;
			if (hit(i_reg_addr, APC_OFS_UIO3))
				uio3_r <= i_reg_wdata & APC_MSK_UIO3;
		end
	end

	// ==========================================================
	// per-lane registers
	// lane writes reach only the lanes the channel index selects
	genvar g;
	generate
		for (g = 0; g < APC_LANES; g++)
		begin : g_lane
			apc_lane_cfg u_lane (
				.i_clock        (i_clock),
				.i_reset        (i_reset),
				.i_write_mode   (i_reg_write && hit(i_reg_addr, APC_OFS_OMODE)
					&& i_data_channel_select[g]),
				.i_write_adjust (i_reg_write && hit(i_reg_addr, APC_OFS_OADJ)
					&& i_clock_channel_select[g]),
				.i_wdata        (i_reg_wdata),
				.o_mode_r       (mode_q[g]),
				.o_adjust_r     (adjust_q[g]),
				.o_cfg          (o_lane_cfg[g])
			);
		end
	endgenerate

	// ==========================================================
	// transfer strobe and override application
	// the transfer byte itself is not stored here
	assign xfer_strobe = i_reg_write && hit(i_reg_addr, APC_OFS_XFER)
		&& i_reg_wdata[APC_XFER_BIT];

	// limits capability, resolution and sampling rate; all three fields load together
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
			o_override <= '0;
		else if (xfer_strobe)
			o_override <= {ovrd_r[6], ovrd_r[5:4], ovrd_r[2:0]};
	end

	// ==========================================================
	// power mode resolution
	// an asserted pin overrides the register; the pin function picks its mode
	always_comb
	begin
		eff_mode_nxt = power_r[1:0];
		if (i_power_down_pin)
			eff_mode_nxt = power_r[APC_PIN_FUNC_BIT] ? APC_PM_STANDBY
				: APC_PM_FULL_DOWN;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_power_ctl       <= '{clock_enable: 1'b1, datapath_reset: 1'b0,
				outputs_enable: 1'b1};
			o_channels_active <= 1'b1;
		end
		else
		begin
			unique case (eff_mode_nxt)
				APC_PM_NORMAL:
					o_power_ctl <= '{1'b1, 1'b0, 1'b1};
				APC_PM_FULL_DOWN:
					o_power_ctl <= '{1'b0, 1'b1, 1'b0};
				APC_PM_STANDBY:
					o_power_ctl <= '{1'b0, 1'b0, 1'b0};
				APC_PM_DIG_RESET:
					o_power_ctl <= '{1'b1, 1'b1, 1'b0};
			endcase
			o_channels_active <= (eff_mode_nxt == APC_PM_NORMAL);
		end
	end

	// ==========================================================
	// global decoded outputs, two cycles after the write
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_chop_enable            <= 1'b0;
			o_input_phase_cycles     <= 3'h0;
			o_data_clock_phase       <= APC_RST_PHASE[3:0];
			o_data_clock_degrees     <= phase_degrees(APC_RST_PHASE[3:0]);
			o_serial_pin_pulldown_en <= 1'b1;
			o_common_mode_gen_down   <= 1'b0;
		end
		else
		begin
			o_chop_enable            <= enh_r[APC_CHOP_BIT];
			// host keeps this at or below the divider ratio
			o_input_phase_cycles     <= phase_r[APC_INPH_LSB +: 3];
			o_data_clock_phase       <= phase_r[3:0];
			o_data_clock_degrees     <= phase_degrees(phase_r[3:0]);
			o_serial_pin_pulldown_en <= ~uio2_r[APC_PULLDN_BIT];
			o_common_mode_gen_down   <= uio3_r[APC_CMGEN_BIT];
		end
	end

	// ==========================================================
	// register readback, one cycle after the read strobe
	always_ff @(posedge i_clock)
	begin
		if (i_reset)
		begin
			o_reg_rdata  <= 8'h00;
			o_reg_rvalid <= 1'b0;
		end
		else
		begin
			o_reg_rvalid <= i_reg_read;
			if (i_reg_read)
			begin
				unique case (i_reg_addr)
					APC_OFS_POWER: o_reg_rdata <= power_r;
					APC_OFS_ENH:   o_reg_rdata <= enh_r;
					APC_OFS_OMODE: o_reg_rdata <= mode_q[lowest_lane(i_data_channel_select)];
					APC_OFS_OADJ:  o_reg_rdata <= adjust_q[lowest_lane(i_clock_channel_select)];
					APC_OFS_PHASE: o_reg_rdata <= phase_r;
					APC_OFS_OVRD:  o_reg_rdata <= ovrd_r;
					APC_OFS_UIO2:  o_reg_rdata <= uio2_r;
					APC_OFS_UIO3:  o_reg_rdata <= uio3_r;
					default:       o_reg_rdata <= 8'h00;
				endcase
			end
		end
	end

	// ==========================================================
	// assertions
	a_pin_full_down: assert property (@(posedge i_clock) disable iff (i_reset)
		i_power_down_pin && !power_r[APC_PIN_FUNC_BIT]
		|=> o_power_ctl == 3'h2)
		else $error("pin did not give full power-down");

	a_pin_standby: assert property (@(posedge i_clock) disable iff (i_reset)
		i_power_down_pin && power_r[APC_PIN_FUNC_BIT]
		|=> o_power_ctl == 3'h0)
		else $error("pin did not give standby");

	a_normal_active: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_power_down_pin && power_r[1:0] == APC_PM_NORMAL
		|=> o_channels_active && o_power_ctl.clock_enable
		&& o_power_ctl.outputs_enable)
		else $error("normal mode not fully active");

	a_full_down_mode: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_power_down_pin && power_r[1:0] == APC_PM_FULL_DOWN
		|=> !o_power_ctl.clock_enable && o_power_ctl.datapath_reset)
		else $error("full power-down not applied");

	a_dig_reset: assert property (@(posedge i_clock) disable iff (i_reset)
		!i_power_down_pin && power_r[1:0] == APC_PM_DIG_RESET
		|=> o_power_ctl.datapath_reset && !o_power_ctl.outputs_enable)
		else $error("digital reset not applied");

	a_power_reg_keep: assert property (@(posedge i_clock) disable iff (i_reset)
		!(i_reg_write && i_reg_addr == APC_OFS_POWER)
		|=> power_r == $past(power_r))
		else $error("power register changed without a write");

	a_override_hold: assert property (@(posedge i_clock) disable iff (i_reset)
		i_reg_write && i_reg_addr == APC_OFS_OVRD && !xfer_strobe
		|=> $stable(o_override))
		else $error("override applied without transfer");

	a_override_xfer: assert property (@(posedge i_clock) disable iff (i_reset)
		xfer_strobe |=> o_override.rate == $past(ovrd_r[2:0])
		&& o_override.enable == $past(ovrd_r[6]))
		else $error("transfer did not apply override");

	a_chop_follow: assert property (@(posedge i_clock) disable iff (i_reset)
		i_reg_write && i_reg_addr == APC_OFS_ENH
		|=> ##1 o_chop_enable == $past(i_reg_wdata[APC_CHOP_BIT], 2))
		else $error("chop bit not applied");

	a_phase_legal: assert property (@(posedge i_clock) disable iff (i_reset)
		o_data_clock_phase <= APC_OUTPH_MAX)
		else $error("illegal output phase code");

	a_pin_pulldown: assert property (@(posedge i_clock) disable iff (i_reset)
		i_reg_write && i_reg_addr == APC_OFS_UIO2
		|=> ##1 o_serial_pin_pulldown_en == !$past(i_reg_wdata[0], 2))
		else $error("pull-down control wrong");

	a_cm_down: assert property (@(posedge i_clock) disable iff (i_reset)
		i_reg_write && i_reg_addr == APC_OFS_UIO3
		|=> ##1 o_common_mode_gen_down == $past(i_reg_wdata[3], 2))
		else $error("common-mode power-down wrong");

	a_term_wins: assert property (@(posedge i_clock) disable iff (i_reset)
		o_lane_cfg[0].termination != 2'h0 |-> !o_lane_cfg[0].double_drive)
		else $error("double drive with termination");

	a_open_zero: assert property (@(posedge i_clock) disable iff (i_reset)
		o_reg_rvalid && $past(i_reg_addr) == APC_OFS_ENH
		|-> (o_reg_rdata & ~APC_MSK_ENH) == 8'h00)
		else $error("open bits read nonzero");

endmodule

//--- test/apc_host_model.sv
// host model issuing byte register accesses over the serial port side
// assumes the register block takes requests on the rising clock edge
`timescale 1ns/1ns
module apc_host_model
	import apc_pkg::*;
#(
	parameter logic [2:0] DIV_RATIO = 3'h7
)
(
	// clock
	input  wire logic       i_clock,
	// register port
	output logic      [8:0] o_reg_addr,
	output logic      [7:0] o_reg_wdata,
	output logic            o_reg_write,
	output logic            o_reg_read,
	input  wire logic [7:0] i_reg_rdata,
	input  wire logic       i_reg_rvalid
);
	// ==========================================================
	// idle bus
	initial
	begin
		o_reg_addr = 9'h000;
		o_reg_wdata = 8'h00;
		o_reg_write = 1'b0;
		o_reg_read = 1'b0;
	end

	// one write, launched at a falling edge, held over one rising edge
	task automatic wr(input logic [8:0] a, input logic [7:0] d);
		logic [7:0] v;
		v = d;
		// phase delay never beyond the divider ratio in use
		if (a == APC_OFS_PHASE && v[6:4] > DIV_RATIO)
			v[6:4] = DIV_RATIO;
		@(negedge i_clock);
		o_reg_addr = a;
		o_reg_wdata = v;
		o_reg_write = 1'b1;
		@(negedge i_clock);
		o_reg_write = 1'b0;
		// released data inverted so stale bytes never look valid
		o_reg_wdata = ~v;
	endtask

	// one read, answer awaited under a bounded count
	task automatic rd(input logic [8:0] a, output logic [7:0] d, output bit ok);
		ok = 1'b0;
		d = 8'h00;
		@(negedge i_clock);
		o_reg_addr = a;
		o_reg_read = 1'b1;
		@(negedge i_clock);
		o_reg_read = 1'b0;
		o_reg_addr = ~a;
		for (int i = 0; i < 4 && !ok; i++)
		begin
			if (i_reg_rvalid === 1'b1)
			begin
				d = i_reg_rdata;
				ok = 1'b1;
			end
			else
				@(negedge i_clock);
		end
	endtask
endmodule

//--- test/tb_top.sv
// self-checking bench for the power and output configuration registers
// assumes the host model drives all register traffic at falling edges
`timescale 1ns/1ns
module tb_top
	import apc_pkg::*;
;
	// ==========================================================
	// signals
	logic                i_clock = 1'b0;
	logic                i_reset;
	logic [8:0]          reg_addr;
	logic [7:0]          reg_wdata;
	logic                reg_write;
	logic                reg_read;
	logic [7:0]          reg_rdata;
	logic                reg_rvalid;
	logic [3:0]          data_sel;
	logic [3:0]          clk_sel;
	logic                pd_pin;
	apc_power_ctl_t      pwr;
	logic                active;
	logic                chop;
	apc_lane_cfg_t [3:0] lane;
	logic [2:0]          in_ph;
	logic [3:0]          out_ph;
	logic [9:0]          deg;
	apc_override_t       ovr;
	logic                pulldn;
	logic                cm_down;
	int                  n_errors = 0;
	int                  comparisons = 0;

	localparam logic [8:0] OFS [8] = '{APC_OFS_POWER, APC_OFS_ENH, APC_OFS_OMODE,
		APC_OFS_OADJ, APC_OFS_PHASE, APC_OFS_OVRD, APC_OFS_UIO2, APC_OFS_UIO3};
	localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h03, 8'h00,
		8'h00, 8'h00};
	localparam logic [7:0] MSK [8] = '{8'h23, 8'h04, 8'h45, 8'h31, 8'h7B, 8'h77,
		8'h01, 8'h08};
	// power control per internal mode: clock, datapath reset, outputs
	localparam logic [2:0] PWR [4] = '{3'h5, 3'h2, 3'h0, 3'h6};

	// 100 ns clock
	always #50 i_clock = ~i_clock;

	// ==========================================================
	// instances
	apc_config_regs u_dut (
		.i_clock                  (i_clock),
		.i_reset                  (i_reset),
		.i_reg_addr               (reg_addr),
		.i_reg_wdata              (reg_wdata),
		.i_reg_write              (reg_write),
		.i_reg_read               (reg_read),
		.o_reg_rdata              (reg_rdata),
		.o_reg_rvalid             (reg_rvalid),
		.i_data_channel_select    (data_sel),
		.i_clock_channel_select   (clk_sel),
		.i_power_down_pin         (pd_pin),
		.o_power_ctl              (pwr),
		.o_channels_active        (active),
		.o_chop_enable            (chop),
		.o_lane_cfg               (lane),
		.o_input_phase_cycles     (in_ph),
		.o_data_clock_phase       (out_ph),
		.o_data_clock_degrees     (deg),
		.o_override               (ovr),
		.o_serial_pin_pulldown_en (pulldn),
		.o_common_mode_gen_down   (cm_down)
	);

	apc_host_model u_host (
		.i_clock      (i_clock),
		.o_reg_addr   (reg_addr),
		.o_reg_wdata  (reg_wdata),
		.o_reg_write  (reg_write),
		.o_reg_read   (reg_read),
		.i_reg_rdata  (reg_rdata),
		.i_reg_rvalid (reg_rvalid)
	);

	// ==========================================================
	// helpers
	task automatic print_verdict();
		if (n_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// a read that never answers ends the run
	task automatic rdc(input logic [8:0] a, input logic [7:0] exp);
		logic [7:0] d;
		bit         ok;
		u_host.rd(a, d, ok);
		if (!ok)
		begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, 8'h00, exp);
			print_verdict();
		end
		else
			chk(d, exp);
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	// termination wins over double clock drive
	function automatic apc_lane_cfg_t exp_lane(input logic [7:0] m, input logic [7:0] a);
		return apc_lane_cfg_t'({m[6], m[2], m[0], a[5:4], a[0] & (a[5:4] == 2'h0)});
	endfunction

	task automatic check_reset();
		for (int i = 0; i < 8; i++)
			rdc(OFS[i], RST[i]);
		chk(pwr, 3'h5);
		chk(active, 1'b1);
		chk(deg, 10'h0B4);
		chk(pulldn, 1'b1);
		chk(lane[3], 6'h08);
		chk(ovr, 6'h00);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		i_reset = 1'b1;
		data_sel = 4'hF;
		clk_sel = 4'hF;
		pd_pin = 1'b0;
		cyc(12);
		i_reset = 1'b0;
		cyc(2);
		check_reset();
		// lane writes gated by the channel selects
		data_sel = 4'h5;
		u_host.wr(APC_OFS_OMODE, 8'h45);
		data_sel = 4'h8;
		u_host.wr(APC_OFS_OMODE, 8'h00);
		clk_sel = 4'h2;
		u_host.wr(APC_OFS_OADJ, 8'h31);
		clk_sel = 4'h8;
		u_host.wr(APC_OFS_OADJ, 8'h01);
		cyc(3);
		chk(lane[0], exp_lane(8'h45, 8'h00));
		chk(lane[1], exp_lane(8'h01, 8'h31));
		chk(lane[2], exp_lane(8'h45, 8'h00));
		chk(lane[3], exp_lane(8'h00, 8'h01));
		data_sel = 4'h4;
		clk_sel = 4'h4;
		rdc(APC_OFS_OMODE, 8'h45);
		data_sel = 4'h2;
		clk_sel = 4'h2;
		rdc(APC_OFS_OADJ, 8'h31);
		// clock phase, then an illegal output code
		u_host.wr(APC_OFS_PHASE, 8'h5B);
		cyc(2);
		chk(in_ph, 3'h5);
		chk(out_ph, 4'hB);
		chk(deg, 10'h294);
		u_host.wr(APC_OFS_PHASE, 8'h1C);
		rdc(APC_OFS_PHASE, 8'h1B);
		// every internal mode, port still served
		for (int m = 0; m < 4; m++)
		begin
			u_host.wr(APC_OFS_POWER, 8'(m));
			cyc(2);
			chk(pwr, PWR[m]);
			chk(active, m == 0);
			rdc(APC_OFS_PHASE, 8'h1B);
		end
		// power-down pin under both pin functions
		pd_pin = 1'b1;
		u_host.wr(APC_OFS_POWER, 8'h20);
		cyc(2);
		chk(pwr, 3'h0);
		u_host.wr(APC_OFS_POWER, 8'h00);
		cyc(2);
		chk(pwr, 3'h2);
		pd_pin = 1'b0;
		cyc(2);
		chk(pwr, 3'h5);
		u_host.wr(APC_OFS_ENH, 8'hFF);
		cyc(2);
		chk(chop, 1'b1);
		// override waits for the transfer strobe
		u_host.wr(APC_OFS_OVRD, 8'h77);
		cyc(3);
		chk(ovr, 6'h00);
		rdc(APC_OFS_OVRD, 8'h77);
		u_host.wr(APC_OFS_XFER, 8'h01);
		cyc(2);
		chk(ovr, 6'h3F);
		u_host.wr(APC_OFS_UIO2, 8'hFF);
		u_host.wr(APC_OFS_UIO3, 8'hFF);
		cyc(2);
		chk(pulldn, 1'b0);
		chk(cm_down, 1'b1);
		// open bits and an unmapped place
		data_sel = 4'hF;
		clk_sel = 4'hF;
		for (int i = 0; i < 8; i++)
		begin
			u_host.wr(OFS[i], 8'hFF);
			rdc(OFS[i], MSK[i]);
		end
		u_host.wr(9'h0AA, 8'hFF);
		rdc(9'h0AA, 8'h00);
		// second power-on reset clears everything again
		i_reset = 1'b1;
		cyc(12);
		i_reset = 1'b0;
		cyc(2);
		check_reset();
		print_verdict();
	end
endmodule
